// >>> core/holdover_cfg_defines.vh
// holdover_cfg_defines.vh: offsets, field positions, reset values, timing
// assumes byte-wide registers, one per aligned 32-bit wishbone word
`ifndef HOLDOVER_CFG_DEFINES_VH
`define HOLDOVER_CFG_DEFINES_VH
`define REG_SW_CTRL 9'h150
`define REG_HEXIT_HI 9'h151
`define REG_HEXIT_LO 9'h152
`define REG_DIV0_HI 9'h153
`define REG_DIV0_LO 9'h154
`define REG_DIV1_HI 9'h155
`define REG_DIV1_LO 9'h156
`define REG_DIV2_HI 9'h157
`define REG_DIV2_LO 9'h158
`define REG_FB_HI 9'h159
`define REG_FB_LO 9'h15a
`define REG_DET_CTRL 9'h15b
`define REG_LOCK_HI 9'h15c
`define REG_LOCK_LO 9'h15d
`define REG_PHASE_ADJ 9'h15e
`define REG_STAT1 9'h15f
`define REG_L2REF_HI 9'h160
`define REG_L2REF_LO 9'h161
`define REG_L2PRE 9'h162
`define REG_MAN_SEL 9'h170
`define REG_STATE 9'h171
`define REG_TRIP 9'h172
// control bits of the switch register
`define B_FORCE 6
`define B_EXIT_MODE 5
`define B_LOCK_SW 4
`define B_EXT_LOSS 3
`define B_RAIL 2
`define B_SW_FLOAT 1
`define B_HOLD_EN 0
// reset values
`define RST_SW_CTRL 8'h00
`define RST_HEXIT 14'h0200
`define RST_DIV0 14'h0078
`define RST_DIV1 14'h0096
`define RST_DIV2 14'h0096
`define RST_FB 14'h0078
`define RST_DET 8'hd4
`define RST_LOCK 14'h2000
`define RST_ADJ 5'h1e
`define RST_STAT1 8'h0e
`define RST_L2REF 12'h002
`define RST_L2PRE 8'h40
`define RST_MAN 2'h0
`define RST_TRIP_LO 6'h00
`define RST_TRIP_HI 6'h00
// lock windows in ns, compared directly with the phase error in ns
`define CLK_NS 10
`define WIN0_NS 4
`define WIN1_NS 9
`define WIN2_NS 19
`define WIN3_NS 43
`define SW_FLOAT_CYC 8'h08
`endif

// >>> core/holdover_cfg.v
// holdover_cfg: loop-1 input switching, holdover and divider configuration
// assumes classic wishbone byte registers and a phase-detector-rate strobe
// Operation
// - force bit with manual mode uses only chosen input, disables dynamic delay
// - exit-mode bit: 0 exits on signal present, 1 on digital lock
// - lock-switch enable turns falling digital lock into switch event
// - external loss mode takes loss from sel pins and status pin 1
// - rail detector marks input invalid and raises switch at trip
// - switch-float bit floats loop-1 pump during every switch
// - holdover allowed only when holdover enable bit is set
// - holdover exits after programmed count of valid detector clocks
// - per-input 14-bit reference dividers, selected one applied, 0 reserved
// - loop-1 feedback divider divides by 1 to 4095
// - lock counter counts when phase error is inside chosen window
// - digital lock set after programmed count of in-window cycles
// - pump float bit puts loop-1 pump output in high impedance
// - pump polarity selects oscillator slope, reset value one
// - holdover exit resets counters and applies signed offset, reset 30
// - status pin 1 type codes: inputs, push-pull, inverted, open-drain
// - loop-2 reference divider is 12 bits, 1 to 4095
// - loop-2 prescale code in bits 7:5, reset code 2
// - manual choice codes: inputs 0,1,2 or 3 for forced holdover
// - rail trip thresholds are 6-bit codes of supply sixty-fourths
//
// The implementer's own choice: register access over Wishbone.
`timescale 1ns/100ps
`default_nettype none
`include "holdover_cfg_defines.vh"
module holdover_cfg (
  // wishbone slave
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [11:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  // loop status inputs
  input wire pd_tick_i,
  input wire [7:0] phase_err_ns_i,
  input wire [2:0] int_loss_i,
  input wire [9:0] dac_code_i,
  input wire [1:0] pin_sel_type_i,
  input wire sel_pin0_i,
  input wire sel_pin1_i,
  input wire status_pin1_i,
  input wire status1_drive_i,
  // configuration and status outputs
  output reg [1:0] active_input_o,
  output reg holdover_o,
  output reg switch_event_o,
  output reg dyn_delay_en_o,
  output reg digital_lock_flag_o,
  output reg loop1_pump_float_o,
  output reg loop1_pump_polarity_o,
  output reg [10:0] loop1_pump_ua_o,
  output reg [13:0] ref_div_o,
  output reg [13:0] loop1_fb_div_o,
  output reg counter_reset_o,
  output reg [4:0] hold_exit_phase_adj_o,
  output reg [11:0] loop2_ref_div_o,
  output reg [3:0] loop2_prescale_o,
  output reg status_pin1_o,
  output reg status_pin1_oe_o
);
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_ACK = 2'b10;
  localparam [2:0] H_RUN = 3'b001;
  localparam [2:0] H_HOLD = 3'b010;
  localparam [2:0] H_EXIT = 3'b100;
  localparam [7:0] WIN0 = (`WIN0_NS);
  localparam [7:0] WIN1 = (`WIN1_NS);
  localparam [7:0] WIN2 = (`WIN2_NS);
  localparam [7:0] WIN3 = (`WIN3_NS);
  localparam [7:0] L2PRE_RST = `RST_L2PRE;

  reg [7:0] sw_ctrl_r;
  reg [13:0] hexit_r;
  reg [13:0] div0_r;
  reg [13:0] div1_r;
  reg [13:0] div2_r;
  reg [13:0] fb_r;
  reg [7:0] det_r;
  reg [13:0] lock_cnt_cfg_r;
  reg [4:0] adj_r;
  reg [7:0] stat1_r;
  reg [11:0] l2ref_r;
  reg [2:0] l2pre_r;
  reg [1:0] man_r;
  reg man_mode_r;
  reg [5:0] trip_lo_r;
  reg [5:0] trip_hi_r;
  reg [1:0] bus_st_r;
  reg [2:0] hst_r;
  reg [13:0] lock_ctr_r;
  reg [13:0] exit_ctr_r;
  reg lock_d_r;
  reg [7:0] float_ctr_r;
  reg [2:0] loss_r;
  reg rail_r;

  wire [8:0] reg_idx;
  wire wr_en;
  reg [7:0] rd_byte;
  reg [7:0] win_ns;
  reg cur_loss;
  reg [1:0] next_input;
  wire [9:0] trip_lo_dac;
  wire [9:0] trip_hi_dac;
  wire lock_fall;
  wire rail_hit;
  wire sw_evt;
  wire exit_ok;

  // byte registers sit at word addresses, index in address bits 10:2
  assign reg_idx = adr_i[10:2];
  assign wr_en = cyc_i & stb_i & we_i & sel_i[0] & (bus_st_r == ST_IDLE);

  // status pin 1 can serve as an input only for type codes 0 to 2
  function pin_is_input;
    input [2:0] t;
    begin
      pin_is_input = (t <= 3'd2);
    end
  endfunction

  function [13:0] div_clip;
    input [13:0] v;
    begin
      div_clip = (v == 14'h0000) ? 14'h0001 : v;
    end
  endfunction

  // rail trip thresholds: (n+1)/64 of supply on a 10-bit dac scale
  // sixty-fourths of supply
  assign trip_lo_dac = {trip_lo_r, 4'h0} + 10'h010;
  assign trip_hi_dac = 10'h3ff - {trip_hi_r, 4'h0} - 10'h00f;

  always @*
  begin
    case (det_r[7:6])
      2'd0: win_ns = WIN0;
      2'd1: win_ns = WIN1;
      2'd2: win_ns = WIN2;
      default: win_ns = WIN3;
    endcase
  end

  always @*
  begin
    if (sw_ctrl_r[`B_EXT_LOSS])
    begin
      loss_r[0] = pin_sel_type_i[0] ? sel_pin0_i : 1'b0;
      loss_r[1] = pin_sel_type_i[1] ? sel_pin1_i : 1'b0;
      loss_r[2] = pin_is_input(stat1_r[2:0]) ? status_pin1_i : 1'b0;
    end
    else
    begin
      loss_r = int_loss_i;
    end
    case (active_input_o)
      2'd0: cur_loss = loss_r[0];
      2'd1: cur_loss = loss_r[1];
      2'd2: cur_loss = loss_r[2];
      default: cur_loss = 1'b1;
    endcase
  end

  // falling lock flag raises switch only when enabled
  assign lock_fall = sw_ctrl_r[`B_LOCK_SW] & lock_d_r & ~digital_lock_flag_o;
  assign rail_hit = sw_ctrl_r[`B_RAIL] & ((dac_code_i <= trip_lo_dac) |
    (dac_code_i >= trip_hi_dac));
  assign sw_evt = lock_fall | rail_hit | ((hst_r == H_RUN) & cur_loss);
  assign exit_ok = sw_ctrl_r[`B_EXIT_MODE] ? digital_lock_flag_o : ~cur_loss;

  // lowest numbered healthy input, 3 when none
  always @*
  begin
    if (~loss_r[0])
      next_input = 2'd0;
    else if (~loss_r[1])
      next_input = 2'd1;
    else if (~loss_r[2])
      next_input = 2'd2;
    else
      next_input = 2'd3;
  end

  // register read mux
  // reserved bits read zero
  always @*
  begin
    case (reg_idx)
      `REG_SW_CTRL: rd_byte = {1'b0, sw_ctrl_r[6:0]};
      `REG_HEXIT_HI: rd_byte = {2'b00, hexit_r[13:8]};
      `REG_HEXIT_LO: rd_byte = hexit_r[7:0];
      `REG_DIV0_HI: rd_byte = {2'b00, div0_r[13:8]};
      `REG_DIV0_LO: rd_byte = div0_r[7:0];
      `REG_DIV1_HI: rd_byte = {2'b00, div1_r[13:8]};
      `REG_DIV1_LO: rd_byte = div1_r[7:0];
      `REG_DIV2_HI: rd_byte = {2'b00, div2_r[13:8]};
      `REG_DIV2_LO: rd_byte = div2_r[7:0];
      `REG_FB_HI: rd_byte = {2'b00, fb_r[13:8]};
      `REG_FB_LO: rd_byte = fb_r[7:0];
      `REG_DET_CTRL: rd_byte = det_r;
      `REG_LOCK_HI: rd_byte = {2'b00, lock_cnt_cfg_r[13:8]};
      `REG_LOCK_LO: rd_byte = lock_cnt_cfg_r[7:0];
      `REG_PHASE_ADJ: rd_byte = {3'b000, adj_r};
      `REG_STAT1: rd_byte = stat1_r;
      `REG_L2REF_HI: rd_byte = {4'h0, l2ref_r[11:8]};
      `REG_L2REF_LO: rd_byte = l2ref_r[7:0];
      `REG_L2PRE: rd_byte = {l2pre_r, 5'h00};
      `REG_MAN_SEL: rd_byte = {5'h00, man_mode_r, man_r};
      `REG_STATE: rd_byte = {2'b00, rail_hit, digital_lock_flag_o, hst_r[2:1],
        active_input_o};
      `REG_TRIP: rd_byte = {2'b00, trip_lo_r};
      default: rd_byte = 8'h00;
    endcase
  end

  // wishbone: ack one cycle after the request, dropped the cycle after
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      bus_st_r <= ST_IDLE;
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end
    else
    begin
      case (bus_st_r)
        ST_IDLE:
        begin
          ack_o <= cyc_i & stb_i;
          dat_o <= {24'h000000, rd_byte};
          if (cyc_i & stb_i)
            bus_st_r <= ST_ACK;
        end
        ST_ACK:
        begin
          ack_o <= 1'b0;
          bus_st_r <= ST_IDLE;
        end
        default: bus_st_r <= ST_IDLE;
      endcase
    end
  end

  // register writes
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sw_ctrl_r <= `RST_SW_CTRL;
      hexit_r <= `RST_HEXIT;
      div0_r <= `RST_DIV0;
      div1_r <= `RST_DIV1;
      div2_r <= `RST_DIV2;
      fb_r <= `RST_FB;
      det_r <= `RST_DET;
      lock_cnt_cfg_r <= `RST_LOCK;
      adj_r <= `RST_ADJ;
      stat1_r <= `RST_STAT1;
      l2ref_r <= `RST_L2REF;
      l2pre_r <= L2PRE_RST[7:5];
      man_r <= `RST_MAN;
      man_mode_r <= 1'b0;
      trip_lo_r <= `RST_TRIP_LO;
      trip_hi_r <= `RST_TRIP_HI;
    end
    else if (wr_en)
    begin
      case (reg_idx)
        `REG_SW_CTRL: sw_ctrl_r <= {1'b0, dat_i[6:0]};
        `REG_HEXIT_HI: hexit_r[13:8] <= dat_i[5:0];
        `REG_HEXIT_LO: hexit_r[7:0] <= dat_i[7:0];
        `REG_DIV0_HI: div0_r[13:8] <= dat_i[5:0];
        `REG_DIV0_LO: div0_r[7:0] <= dat_i[7:0];
        `REG_DIV1_HI: div1_r[13:8] <= dat_i[5:0];
        `REG_DIV1_LO: div1_r[7:0] <= dat_i[7:0];
        `REG_DIV2_HI: div2_r[13:8] <= dat_i[5:0];
        `REG_DIV2_LO: div2_r[7:0] <= dat_i[7:0];
        `REG_FB_HI: fb_r[13:8] <= dat_i[5:0];
        `REG_FB_LO: fb_r[7:0] <= dat_i[7:0];
        `REG_DET_CTRL: det_r <= dat_i[7:0];
        `REG_LOCK_HI: lock_cnt_cfg_r[13:8] <= dat_i[5:0];
        `REG_LOCK_LO: lock_cnt_cfg_r[7:0] <= dat_i[7:0];
        `REG_PHASE_ADJ: adj_r <= dat_i[4:0];
        `REG_STAT1: stat1_r <= dat_i[7:0];
        `REG_L2REF_HI: l2ref_r[11:8] <= dat_i[3:0];
        `REG_L2REF_LO: l2ref_r[7:0] <= dat_i[7:0];
        `REG_L2PRE: l2pre_r <= dat_i[7:5];
        `REG_MAN_SEL:
        begin
          man_r <= dat_i[1:0];
          man_mode_r <= dat_i[2];
        end
        `REG_TRIP:
        begin
          trip_lo_r <= dat_i[5:0];
          trip_hi_r <= dat_i[13:8];
        end
        default: man_mode_r <= man_mode_r;
      endcase
    end
  end

  // lock detector stepping on detector ticks, holdover machine stepping every clock
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      hst_r <= H_RUN;
      lock_ctr_r <= 14'h0000;
      exit_ctr_r <= 14'h0000;
      lock_d_r <= 1'b0;
      digital_lock_flag_o <= 1'b0;
      active_input_o <= 2'd0;
      holdover_o <= 1'b0;
      switch_event_o <= 1'b0;
      counter_reset_o <= 1'b0;
      float_ctr_r <= 8'h00;
      rail_r <= 1'b0;
    end
    else
    begin
      lock_d_r <= digital_lock_flag_o;
      rail_r <= rail_hit;
      switch_event_o <= sw_evt;
      counter_reset_o <= 1'b0;
      if (sw_evt & sw_ctrl_r[`B_SW_FLOAT])
        float_ctr_r <= `SW_FLOAT_CYC;
      else if (float_ctr_r != 8'h00)
        float_ctr_r <= float_ctr_r - 8'h01;
      if (pd_tick_i)
      begin
        if (phase_err_ns_i < win_ns)
        begin
          if (lock_ctr_r < lock_cnt_cfg_r)
            lock_ctr_r <= lock_ctr_r + 14'h0001;
          // flag on the n-th in-window tick, not one later
          if (lock_ctr_r >= lock_cnt_cfg_r - 14'h0001)
            digital_lock_flag_o <= 1'b1;
        end
        else
        begin
          lock_ctr_r <= 14'h0000;
          digital_lock_flag_o <= 1'b0;
        end
      end
      // forced manual input overrides automatic choice
      if (man_mode_r & sw_ctrl_r[`B_FORCE] & (man_r != 2'd3))
      begin
        active_input_o <= man_r;
        hst_r <= H_RUN;
        holdover_o <= 1'b0;
      end
      else if (man_mode_r & (man_r == 2'd3) & sw_ctrl_r[`B_HOLD_EN])
      begin
        hst_r <= H_HOLD;
        holdover_o <= 1'b1;
      end
      else if (~sw_ctrl_r[`B_HOLD_EN] & (hst_r != H_RUN))
      begin
        hst_r <= H_RUN;
        holdover_o <= 1'b0;
      end
      else
      begin
        case (hst_r)
          H_RUN:
            if (sw_evt)
            begin
              if (man_mode_r)
                active_input_o <= man_r;
              else
                active_input_o <= next_input;
              if (sw_ctrl_r[`B_HOLD_EN])
              begin
                hst_r <= H_HOLD;
                holdover_o <= 1'b1;
                exit_ctr_r <= 14'h0000;
              end
            end
          H_HOLD:
          begin
            if (~man_mode_r && next_input != 2'd3)
              active_input_o <= next_input;
            if (exit_ok & ~rail_r)
              hst_r <= H_EXIT;
          end
          H_EXIT:
            if (~exit_ok)
            begin
              hst_r <= H_HOLD;
              exit_ctr_r <= 14'h0000;
            end
            // exit after programmed valid detector clocks
            else if (exit_ctr_r >= hexit_r)
            begin
              hst_r <= H_RUN;
              holdover_o <= 1'b0;
              counter_reset_o <= 1'b1;
            end
            else if (pd_tick_i)
              exit_ctr_r <= exit_ctr_r + 14'h0001;
          default: hst_r <= H_RUN;
        endcase
      end
    end
  end

  // configuration outputs, all registered
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dyn_delay_en_o <= 1'b1;
      loop1_pump_float_o <= 1'b0;
      loop1_pump_polarity_o <= 1'b1;
      loop1_pump_ua_o <= 11'd450;
      ref_div_o <= `RST_DIV0;
      loop1_fb_div_o <= `RST_FB;
      hold_exit_phase_adj_o <= `RST_ADJ;
      loop2_ref_div_o <= `RST_L2REF;
      loop2_prescale_o <= 4'd2;
      status_pin1_o <= 1'b0;
      status_pin1_oe_o <= 1'b0;
    end
    else
    begin
      // dynamic delay off under forced input
      dyn_delay_en_o <= ~(man_mode_r & sw_ctrl_r[`B_FORCE]);
      loop1_pump_float_o <= det_r[5] | (float_ctr_r != 8'h00) |
        (sw_evt & sw_ctrl_r[`B_SW_FLOAT]);
      loop1_pump_polarity_o <= det_r[4];
      // 50 uA plus 100 uA per code
      loop1_pump_ua_o <= 11'd50 + {det_r[3:0], 6'h00} + {1'b0, det_r[3:0], 5'h00} +
        {4'h0, det_r[3:0], 2'b00};
      case (active_input_o)
        2'd0: ref_div_o <= div_clip(div0_r);
        2'd1: ref_div_o <= div_clip(div1_r);
        default: ref_div_o <= div_clip(div2_r);
      endcase
      loop1_fb_div_o <= div_clip({2'b00, fb_r[11:0]});
      hold_exit_phase_adj_o <= adj_r;
      loop2_ref_div_o <= (l2ref_r == 12'h000) ? 12'h001 : l2ref_r;
      case (l2pre_r)
        3'd0: loop2_prescale_o <= 4'd8;
        3'd1: loop2_prescale_o <= 4'd2;
        3'd7: loop2_prescale_o <= 4'd2;
        default: loop2_prescale_o <= {1'b0, l2pre_r};
      endcase
      case (stat1_r[2:0])
        3'd3:
        begin
          status_pin1_o <= status1_drive_i;
          status_pin1_oe_o <= 1'b1;
        end
        3'd4:
        begin
          status_pin1_o <= ~status1_drive_i;
          status_pin1_oe_o <= 1'b1;
        end
        3'd6:
        begin
          status_pin1_o <= 1'b0;
          status_pin1_oe_o <= ~status1_drive_i;
        end
        default:
        begin
          status_pin1_o <= 1'b0;
          status_pin1_oe_o <= 1'b0;
        end
      endcase
    end
  end
endmodule // holdover_cfg
`default_nettype wire

// >>> test/holdover_cfg_sva.sv
// holdover_cfg_sva: port-level checks for holdover_cfg
// assumes a classic wishbone master and synchronous active-high reset
`timescale 1ns/100ps
`default_nettype none
module holdover_cfg_sva (
  // bus
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [11:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  // observed outputs
  input wire logic holdover_o,
  input wire logic loop1_pump_float_o,
  input wire logic loop1_pump_polarity_o,
  input wire logic [10:0] loop1_pump_ua_o,
  input wire logic [13:0] ref_div_o,
  input wire logic [13:0] loop1_fb_div_o,
  input wire logic counter_reset_o,
  input wire logic [4:0] hold_exit_phase_adj_o,
  input wire logic [11:0] loop2_ref_div_o,
  input wire logic [3:0] loop2_prescale_o,
  input wire logic status_pin1_oe_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // shadow of a few control bits; lags the design by one edge on purpose
  logic wr;
  logic hold_en_r;
  logic float_r;
  logic pin_in_r;
  assign wr = cyc_i & stb_i & we_i & ack_o & sel_i[0];
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      hold_en_r <= 1'b0;
      float_r <= 1'b0;
      pin_in_r <= 1'b0;
    end
    else if (wr)
    begin
      if (adr_i[10:2] == 9'h150) hold_en_r <= dat_i[0];
      if (adr_i[10:2] == 9'h15b) float_r <= dat_i[5];
      if (adr_i[10:2] == 9'h15f) pin_in_r <= (dat_i[2:0] < 3'h3);
    end
  end
  property p_ack_lat;
    $rose(cyc_i && stb_i) |=> ack_o;
  endproperty
  a_ack_lat: assert property (p_ack_lat) else $error("ack late");
  property p_ack_pulse;
    ack_o |=> !ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack not one cycle");
  property p_rd_zero;
    ack_o && !we_i |-> dat_o[31:8] == 24'h0;
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("upper read bits set");
  property p_rst_val;
    $fell(rst_i) |-> loop1_pump_polarity_o && hold_exit_phase_adj_o == 5'h1e
      && loop1_pump_ua_o == 11'd450 && ref_div_o == 14'h0078;
  endproperty
  a_rst_val: assert property (p_rst_val) else $error("bad reset outputs");
  property p_ua_step;
    loop1_pump_ua_o % 11'd100 == 11'd50 && loop1_pump_ua_o <= 11'd1550;
  endproperty
  a_ua_step: assert property (p_ua_step) else $error("pump current off grid");
  property p_div_nz;
    ref_div_o != 14'h0 && loop1_fb_div_o != 14'h0 && loop2_ref_div_o != 12'h0;
  endproperty
  a_div_nz: assert property (p_div_nz) else $error("divider at zero");
  property p_presc;
    loop2_prescale_o inside {[4'd2:4'd6], 4'd8};
  endproperty
  a_presc: assert property (p_presc) else $error("bad prescale");
  property p_hold_en;
    !hold_en_r && !$past(hold_en_r) |-> !holdover_o;
  endproperty
  a_hold_en: assert property (p_hold_en) else $error("holdover while disabled");
  property p_float;
    float_r && $past(float_r) |-> loop1_pump_float_o;
  endproperty
  a_float: assert property (p_float) else $error("pump not floated");
  property p_pin_in;
    pin_in_r && $past(pin_in_r) |-> !status_pin1_oe_o;
  endproperty
  a_pin_in: assert property (p_pin_in) else $error("input pin driven");
  property p_cnt_rst;
    counter_reset_o |-> $past(holdover_o) || $past(holdover_o, 2);
  endproperty
  a_cnt_rst: assert property (p_cnt_rst) else $error("counter reset outside exit");
  c_write: cover property (ack_o && we_i);
  c_hold: cover property ($rose(holdover_o));
  c_exit: cover property (counter_reset_o);
  c_pin: cover property (pin_in_r);
endmodule // holdover_cfg_sva
bind holdover_cfg holdover_cfg_sva chk (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
  .sel_i, .dat_i, .dat_o, .ack_o, .holdover_o, .loop1_pump_float_o, .loop1_pump_polarity_o,
  .loop1_pump_ua_o, .ref_div_o, .loop1_fb_div_o, .counter_reset_o, .hold_exit_phase_adj_o,
  .loop2_ref_div_o, .loop2_prescale_o, .status_pin1_oe_o);
`default_nettype wire

// >>> test/holdover_cfg_bench.sv
// holdover_cfg_bench: self-checking bench for holdover_cfg
// assumes 100 MHz clock and one-cycle wishbone answers
`timescale 1ns/100ps
`default_nettype none
module holdover_cfg_bench;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [11:0] adr_i = 12'h0;
  logic [3:0] sel_i = 4'h1;
  logic [31:0] dat_i = 32'h0, dat_o;
  logic ack_o, pd_tick_i = 1'b0, status1_drive_i = 1'b0, sel_pin0_i = 1'b0;
  logic [9:0] dac_code_i = 10'h200;
  logic [1:0] pin_sel_type_i = 2'h0;
  logic [7:0] phase_err_ns_i = 8'h0;
  logic [2:0] int_loss_i = 3'h0;
  logic [1:0] active_input_o;
  logic holdover_o, switch_event_o, dyn_delay_en_o, digital_lock_flag_o, loop1_pump_float_o;
  logic loop1_pump_polarity_o, counter_reset_o, status_pin1_o, status_pin1_oe_o;
  logic [10:0] loop1_pump_ua_o;
  logic [13:0] ref_div_o, loop1_fb_div_o;
  logic [4:0] hold_exit_phase_adj_o;
  logic [11:0] loop2_ref_div_o;
  logic [3:0] loop2_prescale_o;
  int failures = 0, check_count = 0, cycles = 0, sw_count = 0;
  logic cr_seen = 1'b0;
  holdover_cfg uut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
    .ack_o, .pd_tick_i, .phase_err_ns_i, .int_loss_i, .dac_code_i,
    .pin_sel_type_i, .sel_pin0_i, .sel_pin1_i(1'b0), .status_pin1_i(1'b0),
    .status1_drive_i, .active_input_o, .holdover_o, .switch_event_o, .dyn_delay_en_o,
    .digital_lock_flag_o, .loop1_pump_float_o, .loop1_pump_polarity_o, .loop1_pump_ua_o,
    .ref_div_o, .loop1_fb_div_o, .counter_reset_o, .hold_exit_phase_adj_o,
    .loop2_ref_div_o, .loop2_prescale_o, .status_pin1_o, .status_pin1_oe_o);
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    if (counter_reset_o === 1'b1) cr_seen <= 1'b1;
    if (switch_event_o === 1'b1) sw_count <= sw_count + 1;
    if (cycles == 20000)
    begin
      failures = failures + 1;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count = check_count + 1;
    if (got !== exp)
    begin
      failures = failures + 1;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask
  // one classic cycle; entered just after a rising edge
  task automatic wb(input logic w, input logic [8:0] idx, input logic [7:0] d,
    output logic [7:0] q);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= {1'b0, idx, 2'b00};
    dat_i <= {24'h0, d};
    do @(posedge clk_i); while (ack_o !== 1'b1 && ++n < 50);
    if (n >= 50) failures = failures + 1;
    q = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [8:0] idx, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, idx, d, q);
    @(posedge clk_i);
  endtask
  task automatic rd(input string name, input logic [8:0] idx, input logic [7:0] exp);
    logic [7:0] q;
    wb(1'b0, idx, 8'h0, q);
    check(name, exp, q);
  endtask
  task automatic tick(input int n);
    repeat (n)
    begin
      pd_tick_i <= 1'b1;
      @(posedge clk_i);
      pd_tick_i <= 1'b0;
      @(posedge clk_i);
    end
    repeat (2) @(posedge clk_i);
  endtask
  task automatic t_reset();
    logic [8:0] ri [7] = '{9'h151, 9'h154, 9'h156, 9'h15b, 9'h15e, 9'h15f, 9'h162};
    logic [7:0] rv [7] = '{8'h02, 8'h78, 8'h96, 8'hd4, 8'h1e, 8'h0e, 8'h40};
    check("l2div", 2, loop2_ref_div_o);
    check("presc", 2, loop2_prescale_o);
    check("pin_oe", 0, status_pin1_oe_o);
    for (int i = 0; i < 7; i++) rd("reset_reg", ri[i], rv[i]);
  endtask
  task automatic t_access();
    logic [8:0] ai [5] = '{9'h150, 9'h151, 9'h153, 9'h15e, 9'h160};
    logic [7:0] am [5] = '{8'h7f, 8'h3f, 8'h3f, 8'h1f, 8'h0f};
    for (int i = 0; i < 5; i++)
    begin
      wr(ai[i], 8'hff);
      rd("masked", ai[i], am[i]);
    end
    wr(9'h150, 8'h00);
    check("ref_div", 14'h3f78, ref_div_o);
    sel_i <= 4'h0;
    wr(9'h151, 8'h15);
    sel_i <= 4'h1;
    rd("no_sel", 9'h151, 8'h3f);
    wr(9'h1a0, 8'h5a);
    rd("unmapped", 9'h1a0, 8'h00);
  endtask
  task automatic t_div();
    logic [3:0] pe [7] = '{4'd8, 4'd2, 4'd2, 4'd3, 4'd4, 4'd5, 4'd6};
    wr(9'h153, 8'h00);
    wr(9'h154, 8'h00);
    check("ref_div0", 1, ref_div_o);
    wr(9'h153, 8'h3f);
    wr(9'h154, 8'hff);
    check("ref_max", 14'h3fff, ref_div_o);
    wr(9'h159, 8'h0f);
    wr(9'h15a, 8'hff);
    check("fb_max", 14'h0fff, loop1_fb_div_o);
    wr(9'h160, 8'h0f);
    wr(9'h161, 8'hff);
    check("l2_max", 12'hfff, loop2_ref_div_o);
    for (int c = 0; c < 7; c++)
    begin
      wr(9'h162, {c[2:0], 5'h0});
      check("presc", pe[c], loop2_prescale_o);
    end
  endtask
  task automatic t_pump();
    for (int k = 0; k < 16; k++)
    begin
      wr(9'h15b, {4'hd, k[3:0]});
      check("pump_ua", 50 + 100 * k, loop1_pump_ua_o);
    end
    wr(9'h15b, 8'h24);
    check("float", 1, loop1_pump_float_o);
    check("polarity", 0, loop1_pump_polarity_o);
    wr(9'h15b, 8'h14);
    check("unfloat", 0, loop1_pump_float_o);
  endtask
  task automatic t_pin();
    logic [2:0] ty [4] = '{3'h0, 3'h3, 3'h4, 3'h6};
    logic oe;
    for (int t = 0; t < 4; t++)
      for (int d = 0; d < 2; d++)
      begin
        status1_drive_i <= d[0];
        wr(9'h15f, {5'h1, ty[t]});
        oe = (ty[t] == 3'h0) ? 1'b0 : (ty[t] == 3'h6) ? !d[0] : 1'b1;
        check("pin_oe", oe, status_pin1_oe_o);
        if (oe) check("pin", (ty[t] == 3'h3) ? d[0] : !d[0] && ty[t] == 3'h4, status_pin1_o);
      end
  endtask
  task automatic t_lock();
    wr(9'h15c, 8'h00);
    wr(9'h15d, 8'h03);
    phase_err_ns_i <= 8'd5;
    tick(6);
    check("no_lock", 0, digital_lock_flag_o);
    phase_err_ns_i <= 8'd3;
    tick(2);
    check("early", 0, digital_lock_flag_o);
    tick(1);
    check("locked", 1, digital_lock_flag_o);
  endtask
  task automatic t_sw();
    int n0;
    wr(9'h170, 8'h05);
    wr(9'h150, 8'h40);
    check("force_in", 1, active_input_o);
    check("dyn_off", 0, dyn_delay_en_o);
    wr(9'h170, 8'h07);
    wr(9'h150, 8'h01);
    check("forced_hold", 1, holdover_o);
    check("dyn_on", 1, dyn_delay_en_o);
    wr(9'h150, 8'h00);
    check("hold_dis", 0, holdover_o);
    wr(9'h170, 8'h00);
    n0 = sw_count;
    phase_err_ns_i <= 8'd50;
    tick(1);
    check("lock_sw_off", n0, sw_count);
    phase_err_ns_i <= 8'd3;
    tick(3);
    wr(9'h150, 8'h10);
    phase_err_ns_i <= 8'd50;
    tick(1);
    check("lock_sw_on", n0 + 1, sw_count);
    wr(9'h172, 8'h1e);
    wr(9'h150, 8'h06);
    check("rail_below", 0, switch_event_o);
    wr(9'h172, 8'h1f);
    check("rail_trip", 1, switch_event_o);
    check("sw_float", 1, loop1_pump_float_o);
    wr(9'h172, 8'h00);
    dac_code_i <= 10'h3f0;
    repeat (2) @(posedge clk_i);
    check("rail_high", 1, switch_event_o);
    dac_code_i <= 10'h200;
    sel_pin0_i <= 1'b1;
    wr(9'h150, 8'h08);
    check("ext_off", 0, active_input_o);
    pin_sel_type_i <= 2'h1;
    repeat (3) @(posedge clk_i);
    check("ext_loss", 1, active_input_o);
    wr(9'h150, 8'h00);
  endtask
  task automatic t_hold();
    int n;
    int_loss_i <= 3'h7;
    tick(10);
    check("hold_off", 0, holdover_o);
    wr(9'h151, 8'h00);
    wr(9'h152, 8'h04);
    wr(9'h150, 8'h01);
    n = 0;
    while (holdover_o !== 1'b1 && n++ < 20) tick(1);
    check("hold_on", 1, holdover_o);
    int_loss_i <= 3'h0;
    tick(2);
    check("hold_wait", 1, holdover_o);
    tick(6);
    check("hold_exit", 0, holdover_o);
    check("cnt_rst", 1, cr_seen);
  endtask
  initial
  begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_access();
    t_div();
    t_pump();
    t_pin();
    t_lock();
    t_hold();
    t_sw();
    finish_test();
  end
endmodule // holdover_cfg_bench
`default_nettype wire
